// >>> logic/scr_defs.vh
// Register offsets, field positions and reset values of the serializer configuration bank
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

`define SCR_ADDR_RESET      8'h01
`define SCR_ADDR_CFG0       8'h03
`define SCR_ADDR_CFG1       8'h04

`define SCR_RST_FULL_BIT    1
`define SCR_RST_CORE_BIT    0
`define SCR_RST_KEEP_BIT    7
`define SCR_RST_RESET       8'h00
`define SCR_RST_MASK        8'h80

`define SCR_CFG0_CRC_EN     7
`define SCR_CFG0_AUTO_ACK   5
`define SCR_CFG0_FILTER_EN  4
`define SCR_CFG0_PASS_THRU  3
`define SCR_CFG0_OSC_AUTO   1
`define SCR_CFG0_EDGE_SEL   0
`define SCR_CFG0_RESET      8'hd2
`define SCR_CFG0_MASK       8'hbb

`define SCR_CFG1_FAILSAFE   7
`define SCR_CFG1_CRC_CLR    5
`define SCR_CFG1_MODE_SRC   3
`define SCR_CFG1_LEGACY     2
`define SCR_CFG1_RESET      8'h80
`define SCR_CFG1_MASK       8'hbf

`define SCR_CORE_RST_CYCLES 4
`define SCR_FILTER_LEN      2

`endif

// >>> logic/scr_sync_filter.v
// Two-clock glitch filter for one sync or enable input
`timescale 1ns/100ps
`include "scr_defs.vh"

module scr_sync_filter (
    // Clock and control
    input  wire clk_sys,
    input  wire sys_rst,
    input  wire clk_en,
    input  wire filter_en,
    // Data
    input  wire sig_in,
    output reg  sig_out
);

    reg       stable_reg;
    reg [1:0] run_reg;

    // With filter_en set, output follows only after the new level has held for two full cycles; with it clear, output follows at once
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            stable_reg <= 1'b0;
            run_reg    <= 2'h0;
            sig_out    <= 1'b0;
        end else if (clk_en) begin
            if (!filter_en) begin
                stable_reg <= sig_in;
                run_reg    <= 2'h0;
                sig_out    <= sig_in;
            end else if (sig_in == stable_reg) begin
                run_reg <= 2'h0;
                sig_out <= stable_reg;
            end else if (run_reg == (`SCR_FILTER_LEN - 1)) begin
                stable_reg <= sig_in;
                run_reg    <= 2'h0;
                sig_out    <= sig_in;
            end else begin
                run_reg <= run_reg + 2'h1;
            end
        end
    end

endmodule

// >>> logic/scr_config_regs.v
// Serializer control and configuration register bank with soft resets and sync filters
// Function
// - Reset bit 1 resets core and registers
// - Reset bit 0 resets core, keeps registers
// - Config0 bit 7 enables back-channel CRC checker
// - Config0 bit 5 auto-acknowledges remote writes
// - Config0 bit 4 rejects sub-two-cycle sync pulses
// - Config0 bit 3 enables I2C pass-through
// - Config0 bit 1 allows oscillator fallback
// - Config0 bit 0 selects pixel strobe edge
// - Config1 bit 7 sets input failsafe level
// - Config1 bit 5 holds CRC counters cleared
// - Config1 bit 3 picks legacy source
// - Config1 bit 2 sets legacy mode
`timescale 1ns/100ps
`include "scr_defs.vh"

module scr_config_regs #(
    parameter CORE_RST_CYCLES = `SCR_CORE_RST_CYCLES
) (
    // Clock, reset, enable
    input  wire       clk_sys,
    input  wire       sys_rst,
    input  wire       clk_en,
    // Register port from the serial control bus
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    // Pins and core status
    input  wire       mode_sel_pin,
    input  wire       pclk_present,
    input  wire       data_enable_in,
    input  wire       hsync_in,
    input  wire       vsync_in,
    // Controls to the core
    output reg        core_rst,
    output reg        crc_check_en,
    output reg        crc_count_clr,
    output reg        remote_auto_ack,
    output reg        pass_through_en,
    output reg        internal_oscillator,
    output reg        pixel_edge_select,
    output reg        failsafe_low,
    output reg        legacy_compat_mode,
    // Filtered sync inputs
    output wire       data_enable_flt,
    output wire       hsync_flt,
    output wire       vsync_flt
);

    localparam ST_IDLE = 3'b001;
    localparam ST_FULL = 3'b010;
    localparam ST_CORE = 3'b100;

    reg [7:0]  rst_reg;
    reg [7:0]  cfg0_reg;
    reg [7:0]  cfg1_reg;
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [15:0] cnt_reg;
    reg        mode_meta_reg;
    reg        mode_sync_reg;
    reg        pclk_meta_reg;
    reg        pclk_sync_reg;
    reg [2:0]  sync_meta_reg;
    reg [2:0]  sync_reg;

    wire       full_req;
    wire       core_req;
    wire       seq_done;
    wire       regs_clear;

    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    assign full_req = reg_wr && hit(reg_addr, `SCR_ADDR_RESET) && reg_wdata[`SCR_RST_FULL_BIT];
    assign core_req = reg_wr && hit(reg_addr, `SCR_ADDR_RESET) && reg_wdata[`SCR_RST_CORE_BIT];
    assign seq_done = (cnt_reg == (CORE_RST_CYCLES - 1));
    // Full reset wipes the bank on its first cycle
    assign regs_clear = sys_rst || (state_reg == ST_FULL);

    // Pins arrive asynchronously; two flops before use
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_meta_reg <= 1'b0;
            mode_sync_reg <= 1'b0;
            pclk_meta_reg <= 1'b0;
            pclk_sync_reg <= 1'b0;
            sync_meta_reg <= 3'h0;
            sync_reg      <= 3'h0;
        end else if (clk_en) begin
            mode_meta_reg <= mode_sel_pin;
            mode_sync_reg <= mode_meta_reg;
            pclk_meta_reg <= pclk_present;
            pclk_sync_reg <= pclk_meta_reg;
            sync_meta_reg <= {vsync_in, hsync_in, data_enable_in};
            sync_reg      <= sync_meta_reg;
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (full_req)
                    state_next = ST_FULL;
                else if (core_req)
                    state_next = ST_CORE;
            end
            ST_FULL: state_next = ST_CORE;
            ST_CORE: begin
                if (seq_done)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 16'h0000;
            core_rst  <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (state_reg == ST_CORE)
                cnt_reg <= cnt_reg + 16'h0001;
            else
                cnt_reg <= 16'h0000;
            core_rst <= (state_next != ST_IDLE);
        end
    end

    // Register bank; a write during a running sequence is still taken, except in the ST_FULL cycle where the clear wins
    always @(posedge clk_sys) begin
        if (regs_clear) begin
            cfg0_reg <= `SCR_CFG0_RESET;
            cfg1_reg <= `SCR_CFG1_RESET;
            rst_reg  <= `SCR_RST_RESET;
        end else if (clk_en) begin
            if (reg_wr && hit(reg_addr, `SCR_ADDR_CFG0))
                cfg0_reg <= reg_wdata & `SCR_CFG0_MASK;
            if (reg_wr && hit(reg_addr, `SCR_ADDR_CFG1))
                cfg1_reg <= reg_wdata & `SCR_CFG1_MASK;
            if (reg_wr && hit(reg_addr, `SCR_ADDR_RESET)) begin
                rst_reg[`SCR_RST_KEEP_BIT] <= reg_wdata[`SCR_RST_KEEP_BIT];
                rst_reg[`SCR_RST_FULL_BIT] <= reg_wdata[`SCR_RST_FULL_BIT];
                rst_reg[`SCR_RST_CORE_BIT] <= reg_wdata[`SCR_RST_CORE_BIT] & ~reg_wdata[`SCR_RST_FULL_BIT];
            end else if (state_next == ST_IDLE) begin
                rst_reg[`SCR_RST_FULL_BIT] <= 1'b0;
                rst_reg[`SCR_RST_CORE_BIT] <= 1'b0;
            end
        end
    end

    // Control outputs registered from the bank
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            crc_check_en        <= 1'b0;
            crc_count_clr       <= 1'b0;
            remote_auto_ack     <= 1'b0;
            pass_through_en     <= 1'b0;
            internal_oscillator <= 1'b0;
            pixel_edge_select   <= 1'b0;
            failsafe_low        <= 1'b1;
            legacy_compat_mode  <= 1'b0;
        end else if (clk_en) begin
            crc_check_en        <= cfg0_reg[`SCR_CFG0_CRC_EN];
            crc_count_clr       <= cfg1_reg[`SCR_CFG1_CRC_CLR];
            remote_auto_ack     <= cfg0_reg[`SCR_CFG0_AUTO_ACK];
            pass_through_en     <= cfg0_reg[`SCR_CFG0_PASS_THRU];
            internal_oscillator <= cfg0_reg[`SCR_CFG0_OSC_AUTO] & ~pclk_sync_reg;
            pixel_edge_select   <= cfg0_reg[`SCR_CFG0_EDGE_SEL];
            failsafe_low        <= cfg1_reg[`SCR_CFG1_FAILSAFE];
            if (cfg1_reg[`SCR_CFG1_MODE_SRC])
                legacy_compat_mode <= cfg1_reg[`SCR_CFG1_LEGACY];
            else
                legacy_compat_mode <= mode_sync_reg;
        end
    end

    // Read port: one-cycle answer, unmapped offsets read zero
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                if (hit(reg_addr, `SCR_ADDR_CFG0))
                    reg_rdata <= cfg0_reg;
                else if (hit(reg_addr, `SCR_ADDR_CFG1))
                    reg_rdata <= cfg1_reg;
                else if (hit(reg_addr, `SCR_ADDR_RESET))
                    reg_rdata <= rst_reg & {`SCR_RST_MASK | 8'h03};
                else
                    reg_rdata <= 8'h00;
            end
        end
    end

    // Filters held in reset while the core is reset
    scr_sync_filter u_flt_de (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst | core_rst),
        .clk_en    (clk_en),
        .filter_en (cfg0_reg[`SCR_CFG0_FILTER_EN]),
        .sig_in    (sync_reg[0]),
        .sig_out   (data_enable_flt)
    );

    scr_sync_filter u_flt_hs (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst | core_rst),
        .clk_en    (clk_en),
        .filter_en (cfg0_reg[`SCR_CFG0_FILTER_EN]),
        .sig_in    (sync_reg[1]),
        .sig_out   (hsync_flt)
    );

    scr_sync_filter u_flt_vs (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst | core_rst),
        .clk_en    (clk_en),
        .filter_en (cfg0_reg[`SCR_CFG0_FILTER_EN]),
        .sig_in    (sync_reg[2]),
        .sig_out   (vsync_flt)
    );

endmodule

// >>> verif/scr_config_regs_sva.sv
// Port assertions for the configuration bank
`timescale 1ns/100ps
module scr_config_regs_sva #(
    parameter CORE_RST_CYCLES = 4
) (
    // Clock and reset
    input wire       clk_sys,
    input wire       sys_rst,
    input wire       clk_en,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    // Status and controls
    input wire       pclk_present,
    input wire       core_rst,
    input wire       crc_check_en,
    input wire       crc_count_clr,
    input wire       remote_auto_ack,
    input wire       pass_through_en,
    input wire       internal_oscillator,
    input wire       pixel_edge_select,
    input wire       failsafe_low,
    input wire       legacy_compat_mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Full reset clears the bank, so writes during a sequence are left out
    sequence wr0;
        clk_en && reg_wr && reg_addr == 8'h03 && !core_rst ##1 clk_en ##1 clk_en;
    endsequence
    sequence wr1;
        clk_en && reg_wr && reg_addr == 8'h04 && !core_rst ##1 clk_en ##1 clk_en;
    endsequence
    a_crc_enable: assert property (wr0 |-> crc_check_en == $past(reg_wdata[7], 2))
        else $error("crc enable wrong");
    a_auto_ack: assert property (wr0 |-> remote_auto_ack == $past(reg_wdata[5], 2))
        else $error("auto ack wrong");
    a_pass_through: assert property (wr0 |-> pass_through_en == $past(reg_wdata[3], 2))
        else $error("pass through wrong");
    a_edge_select: assert property (wr0 |-> pixel_edge_select == $past(reg_wdata[0], 2))
        else $error("edge select wrong");
    a_failsafe_level: assert property (wr1 |-> failsafe_low == $past(reg_wdata[7], 2))
        else $error("failsafe wrong");
    a_crc_clear: assert property (wr1 |-> crc_count_clr == $past(reg_wdata[5], 2))
        else $error("crc clear wrong");
    a_legacy_source: assert property (wr1 |-> !$past(reg_wdata[3], 2) ||
        legacy_compat_mode == $past(reg_wdata[2], 2)) else $error("legacy wrong");
    a_osc_absent: assert property ((clk_en && pclk_present)[*5] |-> !internal_oscillator)
        else $error("oscillator wrong");
    a_osc_switch: assert property (clk_en && reg_wr && reg_addr == 8'h03 && !core_rst && reg_wdata[1] &&
        !pclk_present ##1 (clk_en && !reg_wr && !pclk_present)[*3] |=> internal_oscillator)
        else $error("oscillator switch wrong");
    a_core_only: assert property (clk_en && reg_wr && reg_addr == 8'h01 && !core_rst &&
        reg_wdata[1:0] == 2'b01 |=> core_rst[*4] ##1 !core_rst) else $error("core reset length");
    a_full_reset: assert property (clk_en && reg_wr && reg_addr == 8'h01 && !core_rst &&
        reg_wdata[1] |=> core_rst[*5] ##1 !core_rst) else $error("full reset length");
endmodule
bind scr_config_regs scr_config_regs_sva #(.CORE_RST_CYCLES(CORE_RST_CYCLES)) u_scr_config_regs_sva (.*);

// >>> verif/scr_host_model.sv
// Host side of the register port
`timescale 1ns/100ps
module scr_host_model (
    // Clock
    input  wire       clk_sys,
    // Register port
    output reg  [7:0] reg_addr = 8'h00,
    output reg  [7:0] reg_wdata = 8'h00,
    output reg        reg_wr = 1'b0,
    output reg        reg_rd = 1'b0,
    input  wire [7:0] reg_rdata,
    input  wire       reg_rvalid
);
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys); #5;
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge clk_sys); #5;
            reg_wr = 1'b0;
            reg_wdata = ~d;  // Stale data never lingers on the bus
        end
    endtask
    task rd(input [7:0] a, output [7:0] d, output ok);
        integer i;
        begin
            @(posedge clk_sys); #5;
            reg_addr = a;
            reg_rd = 1'b1;
            @(posedge clk_sys); #5;
            reg_rd = 1'b0;
            for (i = 0; i < 4 && reg_rvalid !== 1'b1; i = i + 1) begin
                @(posedge clk_sys); #5;
            end
            ok = reg_rvalid === 1'b1;
            d = reg_rdata;
        end
    endtask
endmodule

// >>> verif/scr_config_regs_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/100ps
module scr_config_regs_tb;
    reg        clk_sys = 1'b0;
    reg        sys_rst = 1'b1;
    reg        mode_sel_pin = 1'b0;
    reg        pclk_present = 1'b0;
    reg        clk_en = 1'b1;
    reg  [2:0] sync_in = 3'h0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, outs;
    wire       reg_wr, reg_rd, reg_rvalid, core_rst;
    wire [2:0] flt;
    integer    err_count = 0;
    integer    cmp_count = 0;
    reg  [7:0] rv;
    reg        seen;
    always #25 clk_sys = ~clk_sys;
    scr_host_model u_scr_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    scr_config_regs u_scr_config_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mode_sel_pin(mode_sel_pin),
        .pclk_present(pclk_present), .data_enable_in(sync_in[2]), .hsync_in(sync_in[1]),
        .vsync_in(sync_in[0]), .core_rst(core_rst), .crc_check_en(outs[7]),
        .remote_auto_ack(outs[6]), .pass_through_en(outs[5]), .internal_oscillator(outs[4]),
        .pixel_edge_select(outs[3]), .failsafe_low(outs[2]), .crc_count_clr(outs[1]),
        .legacy_compat_mode(outs[0]), .data_enable_flt(flt[2]), .hsync_flt(flt[1]), .vsync_flt(flt[0]));
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [47:0] nm, input [7:0] exp, input [7:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wt(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #5;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            u_scr_host_model.rd(a, rv, seen);
            if (!seen) begin
                err_count = err_count + 1;
                close_out;
            end else begin
                chk("rdata", exp, rv);
            end
        end
    endtask
    // Pin synchronisers need several edges before outputs settle
    task outc(input [7:0] exp);
        begin
            wt(4);
            chk("outs", exp, outs);
        end
    endtask
    task pulse(input integer n, input [2:0] exp);
        reg [2:0] acc;
        integer   i;
        begin
            acc = 3'h0;
            sync_in = 3'h7;
            wt(n);
            sync_in = 3'h0;
            for (i = 0; i < 8; i = i + 1) begin
                wt(1);
                acc = acc | flt;
            end
            chk("flt", {5'h0, exp}, {5'h0, acc});
        end
    endtask
    initial begin
        wt(2);
        sys_rst = 1'b0;
        rdc(8'h03, 8'hd2);
        rdc(8'h04, 8'h80);
        rdc(8'h01, 8'h00);
        outc(8'h94);
        $display("reset values done");
        pclk_present = 1'b1;
        u_scr_host_model.wr(8'h03, 8'hff);
        rdc(8'h03, 8'hbb);
        outc(8'hec);
        u_scr_host_model.wr(8'h03, 8'h02);
        outc(8'h04);
        pclk_present = 1'b0;
        u_scr_host_model.wr(8'h03, 8'h02);
        outc(8'h14);
        pclk_present = 1'b1;
        $display("primary config done");
        u_scr_host_model.wr(8'h04, 8'h2c);
        rdc(8'h04, 8'h2c);
        outc(8'h03);
        u_scr_host_model.wr(8'h04, 8'h08);
        outc(8'h00);
        mode_sel_pin = 1'b1;
        u_scr_host_model.wr(8'h04, 8'h00);
        outc(8'h01);
        u_scr_host_model.wr(8'h04, 8'h80);
        outc(8'h05);
        mode_sel_pin = 1'b0;
        u_scr_host_model.wr(8'h02, 8'hff);
        rdc(8'h02, 8'h00);
        $display("secondary config done");
        u_scr_host_model.wr(8'h03, 8'h01);
        u_scr_host_model.wr(8'h01, 8'h01);
        chk("core", 8'h01, {7'h0, core_rst});
        wt(8);
        chk("core", 8'h00, {7'h0, core_rst});
        rdc(8'h03, 8'h01);
        rdc(8'h01, 8'h00);
        u_scr_host_model.wr(8'h04, 8'h2c);
        u_scr_host_model.wr(8'h01, 8'h02);
        chk("core", 8'h01, {7'h0, core_rst});
        wt(8);
        chk("core", 8'h00, {7'h0, core_rst});
        rdc(8'h03, 8'hd2);
        rdc(8'h04, 8'h80);
        rdc(8'h01, 8'h00);
        outc(8'h84);
        // Write while the enable is low must be ignored
        clk_en = 1'b0;
        u_scr_host_model.wr(8'h03, 8'h00);
        clk_en = 1'b1;
        rdc(8'h03, 8'hd2);
        $display("soft resets done");
        u_scr_host_model.wr(8'h03, 8'h10);
        pulse(1, 3'h0);
        pulse(2, 3'h7);
        u_scr_host_model.wr(8'h03, 8'h00);
        pulse(1, 3'h7);
        $display("filter done");
        close_out;
    end
endmodule
